// ===== sadc_afe_model.sv
// Comparator model standing for the analog front end
`timescale 1ns/1ps
module sadc_afe_model (
  // Trial code and held input level
  input wire logic [9:0] trial_code_i,
  input wire logic [9:0] level_i,
  // Comparator result
  output logic cmp_above_o
);
  // pin used as analog input only
  // Prompt answer: held input at or above the trial code
  assign cmp_above_o = (level_i >= trial_code_i);
endmodule // sadc_afe_model

// ===== sadc_ctrl.sv
// Converter control top: register slave, triggers, pacing and results
// Operation
// - Store 10-bit code in result byte pair.
// - Justify select picks right or left.
// - Unused result bits read as zero.
// - Eight-bit mode fills high byte only.
// - Eight-bit mode ignores justify select.
// - Eight-bit conversion two converter clocks shorter.
// - Converter clock divides system clock.
// - Start source field picks six triggers.
// - Software start by writing in-progress one.
// - In-progress high for whole conversion.
// - In-progress falling sets done flag, interrupt.
// - Timer width picks low or high overflow.
// - Positive input select drives analog mux.
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_ctrl (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Trigger sources
  input wire logic tmr0_ovf_i,
  input wire logic tmr1_ovf_i,
  input wire logic tmr2_low_ovf_i,
  input wire logic tmr2_high_ovf_i,
  input wire logic tmr3_low_ovf_i,
  input wire logic tmr3_high_ovf_i,
  input wire logic ext_conv_start_pin_i,
  // Analog front end
  input wire logic cmp_above_i,
  output logic sample_o,
  output logic [9:0] trial_code_o,
  output logic [4:0] positive_input_select_o,
  // Interrupt
  output logic irq_o
);
  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  logic [2:0] start_source_sel_r; // Trigger choice
  logic [4:0] conv_clock_divider_r; // Divide ratio minus one
  logic eight_bit_mode_en_r; // Eight-bit resolution
  logic left_justify_sel_r; // Left justification
  logic t2_split_r; // Timer 2 in 8-bit mode
  logic t3_split_r; // Timer 3 in 8-bit mode
  logic [7:0] result_high_byte_r; // Result high byte
  logic [7:0] result_low_byte_r; // Result low byte
  logic [2:0] irq_stat_r; // Sticky events
  logic [2:0] irq_mask_r; // Event enables
  logic [4:0] div_cnt_r; // Converter clock counter
  logic busy_d_r; // Busy one cycle ago
  logic [2:0] pin_sync_r; // Start pin sync and edge
  logic ack_r; // Bus answer
  logic [31:0] rdata_r; // Bus read data
  logic irq_r; // Interrupt line
  logic [4:0] insel_r; // Positive input select
  // Derived signals
  logic wb_req; // New bus request
  logic wr; // Write this cycle
  logic rd; // Read this cycle
  logic ext_rise; // Start pin rising edge
  logic trig; // Selected trigger fired
  logic sw_start; // Software start write
  logic conv_fall; // Conversion completed
  logic [15:0] fmt; // Formatted result
  logic [2:0] w1c; // Status bits cleared by write
  logic [31:0] rmux; // Read mux

  sadc_sar_if sar_link ();

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Format a code into the result byte pair
  function automatic logic [15:0] fmt_code(input logic [9:0] c, input logic lj,
                                          input logic eb);
    // eight bits go to the high byte
    if (eb)
      fmt_code = {c[9:2], 8'h00};
    else if (lj)
      fmt_code = {c, 6'h00};
    else
      fmt_code = {6'h00, c};
  endfunction

  // Write a byte lane selected by sel
  function automatic logic lane(input logic [3:0] s, input int b);
    lane = s[b/8];
  endfunction

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    wb_req = wb_cyc_i && wb_stb_i && !ack_r;
    wr = wb_req && wb_we_i;
    rd = wb_req && !wb_we_i;
  end

  // Bus answer, one cycle after the request
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      ack_r <= 1'b0;
    else
      ack_r <= wb_req;
  end

  // Read mux, unmapped offsets read zero
  always_comb
  begin
    rmux = 32'h0000_0000;
    case (wb_adr_i)
      `SADC_OFS_CONTROL:
      begin
        rmux[`SADC_CTL_SRC_MSB:`SADC_CTL_SRC_LSB] = start_source_sel_r;
        rmux[`SADC_CTL_BUSY_BIT] = sar_link.busy;
        rmux[`SADC_CTL_DONE_BIT] = irq_stat_r[`SADC_IRQ_DONE_BIT];
      end
      `SADC_OFS_CONFIG:
      begin
        rmux[`SADC_CFG_DIV_MSB:`SADC_CFG_DIV_LSB] = conv_clock_divider_r;
        rmux[`SADC_CFG_EIGHT_BIT] = eight_bit_mode_en_r;
        rmux[`SADC_CFG_LJST_BIT] = left_justify_sel_r;
        rmux[`SADC_CFG_T2SPLIT_BIT] = t2_split_r;
        rmux[`SADC_CFG_T3SPLIT_BIT] = t3_split_r;
      end
      `SADC_OFS_INSEL: rmux[4:0] = insel_r;
      `SADC_OFS_RES_HIGH: rmux[7:0] = result_high_byte_r;
      `SADC_OFS_RES_LOW: rmux[7:0] = result_low_byte_r;
      `SADC_OFS_IRQ_STAT: rmux[2:0] = irq_stat_r;
      `SADC_OFS_IRQ_MASK: rmux[2:0] = irq_mask_r;
      default: rmux = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_r <= 32'h0000_0000;
    else if (rd)
      rdata_r <= rmux;
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      start_source_sel_r <= sadc_pkg::SADC_SRC_SW;
      conv_clock_divider_r <= `SADC_RST_DIV;
      eight_bit_mode_en_r <= 1'b0;
      left_justify_sel_r <= 1'b0;
      t2_split_r <= 1'b0;
      t3_split_r <= 1'b0;
      insel_r <= `SADC_RST_INSEL;
      irq_mask_r <= `SADC_RST_MASK;
    end
    else if (wr)
    begin
      // source field written in low byte
      if (wb_adr_i == `SADC_OFS_CONTROL && lane(wb_sel_i, 0))
        start_source_sel_r <= wb_dat_i[`SADC_CTL_SRC_MSB:`SADC_CTL_SRC_LSB];
      if (wb_adr_i == `SADC_OFS_CONFIG && lane(wb_sel_i, 0))
      begin
        conv_clock_divider_r <= wb_dat_i[`SADC_CFG_DIV_MSB:`SADC_CFG_DIV_LSB];
        eight_bit_mode_en_r <= wb_dat_i[`SADC_CFG_EIGHT_BIT];
        left_justify_sel_r <= wb_dat_i[`SADC_CFG_LJST_BIT];
        t2_split_r <= wb_dat_i[`SADC_CFG_T2SPLIT_BIT];
      end
      if (wb_adr_i == `SADC_OFS_CONFIG && lane(wb_sel_i, 8))
        t3_split_r <= wb_dat_i[`SADC_CFG_T3SPLIT_BIT];
      if (wb_adr_i == `SADC_OFS_INSEL && lane(wb_sel_i, 0))
        insel_r <= wb_dat_i[4:0];
      if (wb_adr_i == `SADC_OFS_IRQ_MASK && lane(wb_sel_i, 0))
        irq_mask_r <= wb_dat_i[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // Start pin synchroniser
  // ----------------------------------------------------------------------
  // two flops then edge compare
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      pin_sync_r <= 3'h0;
    else
      pin_sync_r <= {pin_sync_r[1:0], ext_conv_start_pin_i};
  end

  // ----------------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------------
  always_comb
  begin
    ext_rise = pin_sync_r[1] && !pin_sync_r[2];
    // software start needs write of one
    sw_start = wr && wb_adr_i == `SADC_OFS_CONTROL && lane(wb_sel_i, 0) &&
               wb_dat_i[`SADC_CTL_BUSY_BIT];
    case (sadc_pkg::sadc_src_t'(start_source_sel_r))
      sadc_pkg::SADC_SRC_SW: trig = sw_start;
      sadc_pkg::SADC_SRC_T0: trig = tmr0_ovf_i;
      sadc_pkg::SADC_SRC_T2: trig = t2_split_r ? tmr2_low_ovf_i : tmr2_high_ovf_i;
      sadc_pkg::SADC_SRC_T1: trig = tmr1_ovf_i;
      sadc_pkg::SADC_SRC_EXT: trig = ext_rise;
      sadc_pkg::SADC_SRC_T3: trig = t3_split_r ? tmr3_low_ovf_i : tmr3_high_ovf_i;
      default: trig = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Engine link
  // ----------------------------------------------------------------------
  always_comb
  begin
    // Triggers during a conversion are dropped
    sar_link.start = trig && !sar_link.busy;
    sar_link.eight_bit = eight_bit_mode_en_r;
    sar_link.tick = sar_link.busy && div_cnt_r == conv_clock_divider_r;
    sar_link.cmp = cmp_above_i;
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      div_cnt_r <= 5'h00;
    else if (!sar_link.busy || sar_link.tick)
      div_cnt_r <= 5'h00;
    else
      div_cnt_r <= div_cnt_r + 5'h01;
  end

  sadc_sar u_sar (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .sar (sar_link.sar)
  );

  // ----------------------------------------------------------------------
  // Completion and results
  // ----------------------------------------------------------------------
  always_comb
  begin
    conv_fall = busy_d_r && !sar_link.busy;
    fmt = fmt_code(sar_link.code, left_justify_sel_r, eight_bit_mode_en_r);
  end

  // Busy history
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      busy_d_r <= 1'b0;
    else
      busy_d_r <= sar_link.busy;
  end

  // both bytes loaded together at completion
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      result_high_byte_r <= 8'h00;
      result_low_byte_r <= 8'h00;
    end
    else if (conv_fall)
    begin
      result_high_byte_r <= fmt[15:8];
      result_low_byte_r <= fmt[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  always_comb
  begin
    w1c = 3'h0;
    if (wr && wb_adr_i == `SADC_OFS_IRQ_STAT && lane(wb_sel_i, 0))
      w1c = wb_dat_i[2:0];
    if (wr && wb_adr_i == `SADC_OFS_CONTROL && lane(wb_sel_i, 0))
      w1c[`SADC_IRQ_DONE_BIT] = wb_dat_i[`SADC_CTL_DONE_BIT];
  end

  // sticky bits, set wins over clear
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      irq_stat_r <= 3'h0;
    else
      irq_stat_r <= (irq_stat_r & ~w1c) |
                    {ext_rise, trig && sar_link.busy, conv_fall};
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_stat_r & irq_mask_r);
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_comb
  begin
    wb_ack_o = ack_r;
    wb_dat_o = rdata_r;
    irq_o = irq_r;
    sample_o = sar_link.sample;
    trial_code_o = sar_link.trial;
    positive_input_select_o = insel_r;
  end
endmodule // sadc_ctrl

// ===== sadc_ctrl_asserts.sv
// Concurrent checks on the converter control top ports
`timescale 1ns/1ps
module sadc_ctrl_asserts (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Front end and interrupt
  input wire logic sample_o,
  input wire logic [9:0] trial_code_o,
  input wire logic [4:0] positive_input_select_o,
  input wire logic irq_o
);
  // ----------------------------------------------------------------------
  // Shared clock and reset for every check
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  // Ack is a single-cycle pulse
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // Every taken request is answered next cycle
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  // No answer without a request
  a_ack_silent: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  // Reads above the last register offset return zero
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h18 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // Result bytes never carry upper bits
  a_result_upper: assert property (wb_ack_o && !wb_we_i && (wb_adr_i == 8'h0C || wb_adr_i == 8'h10)
    |-> wb_dat_o[31:8] == 24'h0)
    else $error("result register upper bits set");
  // Track phase ends within the largest divided period
  a_track_bounded: assert property ($rose(sample_o) |-> ##[1:32] !sample_o)
    else $error("track phase too long");
  // First trial after tracking is the top bit
  a_trial_msb: assert property ($fell(sample_o) |-> trial_code_o == 10'h200)
    else $error("first trial code wrong");
  // Input select moves only on a write to its register
  a_select_write: assert property ($changed(positive_input_select_o)
    |-> wb_ack_o && wb_we_i && wb_adr_i == 8'h08)
    else $error("input select changed without write");
  // Interrupt drops only after a register write
  a_irq_clear: assert property ($fell(irq_o) |-> $past(wb_ack_o) && $past(wb_we_i))
    else $error("interrupt fell without write");
endmodule // sadc_ctrl_asserts

bind sadc_ctrl sadc_ctrl_asserts u_sadc_ctrl_asserts (
  .clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sample_o(sample_o), .trial_code_o(trial_code_o),
  .positive_input_select_o(positive_input_select_o), .irq_o(irq_o)
);

// ===== sadc_map.svh
// Register map, field positions and reset values of the converter control
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SADC_OFS_CONTROL 8'h00
`define SADC_OFS_CONFIG 8'h04
`define SADC_OFS_INSEL 8'h08
`define SADC_OFS_RES_HIGH 8'h0C
`define SADC_OFS_RES_LOW 8'h10
`define SADC_OFS_IRQ_STAT 8'h14
`define SADC_OFS_IRQ_MASK 8'h18
// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define SADC_CTL_SRC_LSB 0
`define SADC_CTL_SRC_MSB 2
`define SADC_CTL_BUSY_BIT 4
`define SADC_CTL_DONE_BIT 5
// ----------------------------------------------------------------------
// Config register fields
// ----------------------------------------------------------------------
`define SADC_CFG_DIV_LSB 0
`define SADC_CFG_DIV_MSB 4
`define SADC_CFG_EIGHT_BIT 5
`define SADC_CFG_LJST_BIT 6
`define SADC_CFG_T2SPLIT_BIT 7
`define SADC_CFG_T3SPLIT_BIT 8
// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define SADC_IRQ_DONE_BIT 0
`define SADC_IRQ_OVR_BIT 1
`define SADC_IRQ_EXT_BIT 2
// ----------------------------------------------------------------------
// Widths, reset values and trial bit indexes
// ----------------------------------------------------------------------
`define SADC_CODE_W 10
`define SADC_DIV_W 5
`define SADC_INSEL_W 5
`define SADC_IRQ_W 3
`define SADC_RST_DIV 5'h1F
`define SADC_RST_INSEL 5'h00
`define SADC_RST_MASK 3'h0
`define SADC_MSB_IDX 4'h9
`define SADC_LAST_IDX_10 4'h0
`define SADC_LAST_IDX_8 4'h2
`endif

// ===== sadc_pkg.sv
// Types shared by the converter control modules
package sadc_pkg;
  // Conversion trigger choices
  typedef enum logic [2:0] {
    SADC_SRC_SW = 3'h0,
    SADC_SRC_T0 = 3'h1,
    SADC_SRC_T2 = 3'h2,
    SADC_SRC_T1 = 3'h3,
    SADC_SRC_EXT = 3'h4,
    SADC_SRC_T3 = 3'h5
  } sadc_src_t;
  // Approximation engine states, one-hot
  typedef enum logic [2:0] {
    SADC_ST_IDLE = 3'b001,
    SADC_ST_TRACK = 3'b010,
    SADC_ST_CONV = 3'b100
  } sadc_state_t;
endpackage

// ===== sadc_sar.sv
// Successive approximation engine stepped by the converter clock
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_sar (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Control side
  sadc_sar_if.sar sar
);
  sadc_pkg::sadc_state_t state_r; // Engine state
  logic [3:0] idx_r; // Bit under trial
  logic eight_r; // Resolution caught at start
  logic [9:0] kept; // Trial with current bit judged
  logic [3:0] last_idx; // Final bit index

  // Bit mask for one index
  function automatic logic [9:0] bit_of(input logic [3:0] i);
    bit_of = 10'h001 << i;
  endfunction

  // Judge the current bit
  always_comb
  begin
    kept = sar.cmp ? sar.trial : (sar.trial & ~bit_of(idx_r));
    last_idx = eight_r ? `SADC_LAST_IDX_8 : `SADC_LAST_IDX_10;
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r <= sadc_pkg::SADC_ST_IDLE;
      idx_r <= 4'h0;
      eight_r <= 1'b0;
      sar.busy <= 1'b0;
      sar.sample <= 1'b0;
      sar.trial <= 10'h000;
      sar.code <= 10'h000;
    end
    else
    begin
      case (state_r)
        sadc_pkg::SADC_ST_IDLE:
        begin
          // Accept a start, begin tracking
          if (sar.start)
          begin
            state_r <= sadc_pkg::SADC_ST_TRACK;
            eight_r <= sar.eight_bit;
            sar.busy <= 1'b1;
            sar.sample <= 1'b1;
          end
        end
        sadc_pkg::SADC_ST_TRACK:
        begin
          // One converter clock of tracking
          if (sar.tick)
          begin
            state_r <= sadc_pkg::SADC_ST_CONV;
            sar.sample <= 1'b0;
            idx_r <= `SADC_MSB_IDX;
            sar.trial <= bit_of(`SADC_MSB_IDX);
          end
        end
        sadc_pkg::SADC_ST_CONV:
        begin
          if (sar.tick && idx_r == last_idx)
          begin
            state_r <= sadc_pkg::SADC_ST_IDLE;
            sar.code <= kept;
            sar.trial <= 10'h000;
            sar.busy <= 1'b0;
          end
          else if (sar.tick)
          begin
            idx_r <= idx_r - 4'h1;
            sar.trial <= kept | bit_of(idx_r - 4'h1);
          end
        end
        default:
        begin
          state_r <= sadc_pkg::SADC_ST_IDLE;
          sar.busy <= 1'b0;
          sar.sample <= 1'b0;
        end
      endcase
    end
  end
endmodule // sadc_sar

// ===== sadc_sar_if.sv
// Link between the control logic and the approximation engine
`timescale 1ns/1ps
interface sadc_sar_if;
  logic start; // One-cycle start request
  logic eight_bit; // Eight-bit resolution
  logic tick; // Converter clock pulse
  logic cmp; // Comparator: input at or above trial
  logic busy; // Conversion running
  logic sample; // Track phase
  logic [9:0] trial; // Trial code to the DAC
  logic [9:0] code; // Finished code
  modport ctrl (output start, eight_bit, tick, cmp, input busy, sample, trial, code);
  modport sar (input start, eight_bit, tick, cmp, output busy, sample, trial, code);
endinterface

// ===== testbench.sv
// Self-checking bench for the converter control top
`timescale 1ns/1ps
module testbench;
  // Clock, reset and bus master drive
  logic clock_i, reset_i, cyc, stb, we;
  logic [7:0] adr;
  logic [31:0] wdat, q, wb_dat_o;
  logic wb_ack_o, cmp, sample_o, irq_o;
  logic [9:0] trial_code_o, lvl;
  logic [4:0] sel_o;
  logic [6:0] trig; // Timer overflows and start pin
  int bad_count, checked;
  // Device under test
  sadc_ctrl u_sadc_ctrl (
    .clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tmr0_ovf_i(trig[0]), .tmr1_ovf_i(trig[1]), .tmr2_low_ovf_i(trig[2]),
    .tmr2_high_ovf_i(trig[3]), .tmr3_low_ovf_i(trig[4]), .tmr3_high_ovf_i(trig[5]),
    .ext_conv_start_pin_i(trig[6]), .cmp_above_i(cmp), .sample_o(sample_o),
    .trial_code_o(trial_code_o), .positive_input_select_o(sel_o), .irq_o(irq_o)
  );
  // Comparator partner
  sadc_afe_model u_sadc_afe_model (.trial_code_i(trial_code_o), .level_i(lvl), .cmp_above_o(cmp));
  // 125 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic end_sim;
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  // Classic single bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock_i);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (i == 20) begin bad_count++; end_sim; end
  endtask
  // Bounded wait for the interrupt line
  task automatic wait_irq(input int lim, output int n);
    for (n = 0; n < lim && irq_o !== 1'b1; n++) @(posedge clock_i);
  endtask
  // Clear all status bits and see the interrupt drop
  task automatic clr;
    wb(1'b1, 8'h14, 32'h7);
    @(posedge clock_i);
    check32({31'h0, irq_o}, 32'h0);
  endtask
  // One trigger pulse; the start pin is held a few cycles
  task automatic pulse(input int i);
    @(posedge clock_i);
    // start pin owned by the converter
    trig[i] <= 1'b1;
    repeat (i == 6 ? 4 : 1) @(posedge clock_i);
    trig[i] <= 1'b0;
  endtask
  // Software-started conversion, counts cycles to interrupt
  task automatic conv(input logic [9:0] l, input logic [31:0] cfg, output int n);
    lvl <= l;
    wb(1'b1, 8'h04, cfg);
    wb(1'b1, 8'h18, 32'h1);
    wb(1'b1, 8'h00, 32'h10);
    wb(1'b0, 8'h00, 32'h0);
    check32(q & 32'h30, 32'h10);
    wait_irq(2000, n);
    if (irq_o !== 1'b1) begin bad_count++; end_sim; end
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    wb(1'b0, 8'h04, 32'h0);
    check32(q, 32'h1F);
    wb(1'b0, 8'h18, 32'h0);
    check32(q, 32'h0);
    wb(1'b1, 8'h1C, 32'hFFFFFFFF);
    wb(1'b0, 8'h1C, 32'h0);
    check32(q, 32'h0);
    wb(1'b0, 8'h0C, 32'h0);
    check32(q, 32'h0);
  endtask
  task automatic t_sel;
    wb(1'b1, 8'h08, 32'h0B);
    wb(1'b0, 8'h08, 32'h0);
    check32(q, 32'h0B);
    check32({27'h0, sel_o}, 32'h0B);
  endtask
  // Codes under both justifications and eight-bit mode
  task automatic t_format;
    int n, k;
    logic [9:0] lv [8] = '{10'h3FF, 10'h3FF, 10'h200, 10'h100, 10'h0, 10'h2A5, 10'h2A5, 10'h2A5};
    logic [31:0] cf [8] = '{32'h0, 32'h40, 32'h40, 32'h0, 32'h40, 32'h0, 32'h60, 32'h20};
    logic [31:0] hi [8] = '{32'h03, 32'hFF, 32'h80, 32'h01, 32'h0, 32'h02, 32'hA9, 32'hA9};
    logic [31:0] lo [8] = '{32'hFF, 32'hC0, 32'h0, 32'h0, 32'h0, 32'hA5, 32'h0, 32'h0};
    for (k = 0; k < 8; k++)
    begin
      conv(lv[k], cf[k], n);
      wb(1'b0, 8'h00, 32'h0);
      check32(q & 32'h30, 32'h20);
      wb(1'b0, 8'h0C, 32'h0);
      check32(q, hi[k]);
      wb(1'b0, 8'h10, 32'h0);
      check32(q, lo[k]);
      clr;
    end
  endtask
  // Conversion lengths against resolution and divider
  task automatic t_timing;
    int a, b, c, d;
    conv(10'h3FF, 32'h0, a);
    clr;
    conv(10'h3FF, 32'h20, b);
    clr;
    conv(10'h3FF, 32'h1, c);
    clr;
    conv(10'h3FF, 32'h21, d);
    clr;
    check32(32'(a - b), 32'h2);
    check32(32'(c - a), 32'hB);
    check32(32'(c - d), 32'h4);
  endtask
  // Masked completion, sticky flag, unmask and clear
  task automatic t_irq;
    int n;
    wb(1'b1, 8'h18, 32'h0);
    wb(1'b1, 8'h00, 32'h10);
    // Second start while busy is dropped and flagged
    wb(1'b1, 8'h00, 32'h10);
    wait_irq(60, n);
    check32({31'h0, irq_o}, 32'h0);
    wb(1'b0, 8'h14, 32'h0);
    check32(q & 32'h3, 32'h3);
    wb(1'b1, 8'h18, 32'h1);
    @(posedge clock_i);
    check32({31'h0, irq_o}, 32'h1);
    clr;
    wb(1'b0, 8'h14, 32'h0);
    check32(q & 32'h1, 32'h0);
  endtask
  // Each timer and start pin source: a foreign trigger is ignored, its own starts
  task automatic t_trig;
    int n, k;
    logic [31:0] src [7] = '{32'h1, 32'h2, 32'h2, 32'h3, 32'h4, 32'h5, 32'h5};
    logic [31:0] cf [7] = '{32'h0, 32'h0, 32'h80, 32'h0, 32'h0, 32'h0, 32'h100};
    int wr [7] = '{1, 2, 3, 0, 5, 4, 5};
    int rt [7] = '{0, 3, 2, 1, 6, 5, 4};
    for (k = 0; k < 7; k++)
    begin
      wb(1'b1, 8'h04, cf[k]);
      wb(1'b1, 8'h18, 32'h1);
      // Source first: a start bit in the same write would still see the old source
      wb(1'b1, 8'h00, src[k]);
      wb(1'b1, 8'h00, 32'h10 | src[k]);
      pulse(wr[k]);
      wait_irq(40, n);
      check32({31'h0, irq_o}, 32'h0);
      pulse(rt[k]);
      wait_irq(200, n);
      check32({31'h0, irq_o}, 32'h1);
      wb(1'b0, 8'h14, 32'h0);
      check32(q & 32'h4, rt[k] == 6 ? 32'h4 : 32'h0);
      clr;
    end
  endtask
  // Main sequence
  initial
  begin
    reset_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    lvl = 10'h0;
    trig = 7'h0;
    bad_count = 0;
    checked = 0;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    t_reset;
    t_sel;
    t_format;
    t_timing;
    t_irq;
    t_trig;
    end_sim;
  end
endmodule // testbench
